// >>> dcc_top.sv
// Two-channel DMA control registers and transfer sequencing
//
// Summary of operation
// RULE1 - Bits 31..19 and bit 7 always read zero; software writes zero there.
// RULE2 - Power-on reset and standby entry clear both control registers.
// RULE3 - Transfer-end flag clears only by writing zero after reading one.
// RULE4 - Bit 18 picks accept strobe polarity: zero high, one low.
// RULE5 - Dual address: bit 17 puts acknowledge in read or write cycle.
// RULE6 - Single address: acknowledge is always driven for every transfer.
// RULE7 - Bit 16 picks acknowledge polarity: zero high, one low.
// RULE8 - Bits 15:14 keep, increment or decrement destination by transfer size.
// RULE9 - Bits 13:12 keep, increment or decrement source by 1, 2 or 4.
// RULE10 - Device-to-memory single address transfers ignore both step fields.
// RULE11 - Bits 11:8 choose external, auto or peripheral request source.
// RULE12 - Codes: 0 dual, 2 mem-to-dev, 3 dev-to-mem, 4 auto, others peripheral.
// RULE13 - Bit 6 picks low-level or falling-edge external request sampling.
// RULE14 - Transfers run only when enabled; count end sets flag, and interrupt when bit 2 is set; irq also needs the mask bit set.
// RULE15 - Reserved writes have no effect; value holds until rewrite or reset.
`timescale 1ns/1ps
module dcc_top (
  // Clock, reset and standby
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             standby_enter,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // Request pins and peripheral events
  input  wire logic [1:0]       transfer_request_in_n,
  input  wire logic [15:0]      periph_evt,
  output logic [1:0]            request_accepted_strobe,
  output logic [1:0]            transfer_ack_out,
  // Address and count interface
  input  wire logic [1:0]       count_last,
  output logic [1:0]            xfer_done,
  output logic [1:0][3:0]       src_step,
  output logic [1:0][3:0]       dst_step,
  // Interrupt
  output logic                  irq
);

  // All state of the block in one word
  typedef struct packed {
    // Software-visible control, one word per channel
    logic [1:0][31:0]           ctrl;
    // Flag read back as one, so a zero write may clear it
    logic [1:0]                 end_seen;
    // Per-channel transfer sequencers
    dcc_pkg::dcc_state_t [1:0]  st;
    // Pin strobes before polarity
    logic [1:0]                 acc;
    logic [1:0]                 ack;
    // Transfer end pulses and latched steps
    logic [1:0]                 done;
    logic [1:0][3:0]            sstep;
    logic [1:0][3:0]            dstep;
    // Interrupt status and mask
    logic [1:0]                 stat;
    logic [1:0]                 mask;
    // Read data, one cycle after the strobe
    logic [31:0]                rdata;
  } dcc_regs_t;

  dcc_regs_t        q;
  dcc_regs_t        d;
  logic [1:0]       pend;
  logic [1:0]       take;
  logic [1:0][3:0]  s_calc;
  logic [1:0][3:0]  d_calc;

  // Control register address for a channel
  function automatic logic ctrl_hit(input logic [7:0] a,
                                    input int         c);
    if (c == 0) begin
      ctrl_hit = (a == dcc_pkg::ADDR_CTRL0);
    end else begin
      ctrl_hit = (a == dcc_pkg::ADDR_CTRL1);
    end
  endfunction : ctrl_hit

  // Request source field of a control word
  function automatic logic [3:0] src_of(input logic [31:0] w);
    src_of = w[dcc_pkg::POS_REQ_SRC +: 4];
  endfunction : src_of

  // Control word as software reads it
  function automatic logic [31:0] ctrl_view(input logic [31:0] w);
    ctrl_view = w & dcc_pkg::CTRL_RMASK; // RULE1
  endfunction : ctrl_view

  // Control word after a write; reserved bits are kept, flag bit kept unless armed and zero is written
  function automatic logic [31:0] ctrl_write(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic        armed);
    logic [31:0] keep;
    keep       = old & ~dcc_pkg::CTRL_WMASK; // RULE15
    ctrl_write = (wdata & dcc_pkg::CTRL_WMASK) | keep; // RULE1
    if (armed && !wdata[dcc_pkg::POS_END_FLAG]) begin
      ctrl_write[dcc_pkg::POS_END_FLAG] = 1'b0; // RULE3
    end
  endfunction : ctrl_write

  // First state after a request is taken
  function automatic dcc_pkg::dcc_state_t entry_state(input logic single);
    if (single) begin
      entry_state = dcc_pkg::ST_WR;
    end else begin
      entry_state = dcc_pkg::ST_RD;
    end
  endfunction : entry_state

  // Sequencer state that carries the acknowledge
  function automatic logic ack_cycle(input logic                single,
                                     input logic                late,
                                     input dcc_pkg::dcc_state_t st);
    if (single) begin
      ack_cycle = (st == dcc_pkg::ST_WR); // RULE6
    end else if (late) begin
      ack_cycle = (st == dcc_pkg::ST_WR); // RULE5
    end else begin
      ack_cycle = (st == dcc_pkg::ST_RD); // RULE5
    end
  endfunction : ack_cycle

  // Per-channel request detection and step computation
  for (genvar g = 0; g < dcc_pkg::NCH; g++) begin : g_ch
    logic [3:0] src;
    logic       ign;

    assign src = src_of(q.ctrl[g]); // RULE11
    assign ign = (src == dcc_pkg::SRC_EXT_D2M); // RULE10

    dcc_req_detect u_req (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .clear                 (standby_enter),
      .transfer_request_in_n (transfer_request_in_n[g]),
      .periph_evt            (periph_evt),
      .source                (src),
      .sample_sel            (q.ctrl[g][dcc_pkg::POS_REQ_SAMPLE]),
      .enable                (q.ctrl[g][dcc_pkg::POS_CH_EN]),
      .take                  (take[g]),
      .pending               (pend[g])
    );

    dcc_step u_src (
      .mode   (q.ctrl[g][dcc_pkg::POS_SRC_STEP +: 2]), // RULE9
      .size   (q.ctrl[g][dcc_pkg::POS_XFER_SIZE +: 2]),
      .ignore (ign),
      .step   (s_calc[g])
    );

    dcc_step u_dst (
      .mode   (q.ctrl[g][dcc_pkg::POS_DST_STEP +: 2]), // RULE8
      .size   (q.ctrl[g][dcc_pkg::POS_XFER_SIZE +: 2]),
      .ignore (ign),
      .step   (d_calc[g])
    );
  end

  // Next-state logic: bus access, sequencers, status
  always_comb begin
    logic [3:0]  src;
    logic        single;
    logic        run;
    logic        late;
    src    = 4'h0;
    single = 1'b0;
    run    = 1'b0;
    late   = 1'b0;
    d      = q;
    take   = 2'b00;
    d.acc  = 2'b00;
    d.done = 2'b00;
    d.rdata = 32'h0000_0000;

    // Register reads, data in the following cycle only
    if (reg_rd) begin
      for (int c = 0; c < dcc_pkg::NCH; c++) begin
        if (ctrl_hit(reg_addr, c)) begin
          d.rdata = ctrl_view(q.ctrl[c]); // RULE1
          if (q.ctrl[c][dcc_pkg::POS_END_FLAG]) begin
            d.end_seen[c] = 1'b1; // RULE3
          end
        end
      end
      if (reg_addr == dcc_pkg::ADDR_STAT) begin
        d.rdata[1:0] = q.stat;
        d.stat       = 2'b00;
      end
      if (reg_addr == dcc_pkg::ADDR_MASK) begin
        d.rdata[1:0] = q.mask;
      end
    end

    // Register writes
    if (reg_wr) begin
      for (int c = 0; c < dcc_pkg::NCH; c++) begin
        if (ctrl_hit(reg_addr, c)) begin
          d.ctrl[c] = ctrl_write(q.ctrl[c], reg_wdata, q.end_seen[c]); // RULE15
          if (!reg_wdata[dcc_pkg::POS_END_FLAG] && q.end_seen[c]) begin
            d.end_seen[c] = 1'b0; // RULE3
          end
        end
      end
      if (reg_addr == dcc_pkg::ADDR_MASK) begin
        d.mask = reg_wdata[1:0];
      end
    end

    // Channel sequencers
    for (int c = 0; c < dcc_pkg::NCH; c++) begin
      src    = src_of(q.ctrl[c]);
      single = dcc_pkg::is_single(src); // RULE12
      late   = q.ctrl[c][dcc_pkg::POS_ACK_TIME];
      run    = q.ctrl[c][dcc_pkg::POS_CH_EN] && !q.ctrl[c][dcc_pkg::POS_END_FLAG];
      case (q.st[c])
        dcc_pkg::ST_IDLE: begin
          if (run && pend[c]) begin // RULE14
            take[c]  = 1'b1;
            d.acc[c] = 1'b1;
            d.st[c]  = entry_state(single);
          end
        end
        dcc_pkg::ST_RD: begin
          d.st[c] = dcc_pkg::ST_WR;
        end
        dcc_pkg::ST_WR: begin
          d.st[c] = dcc_pkg::ST_END;
        end
        dcc_pkg::ST_END: begin
          d.st[c]    = dcc_pkg::ST_IDLE;
          d.done[c]  = 1'b1;
          d.sstep[c] = s_calc[c]; // RULE9
          d.dstep[c] = d_calc[c]; // RULE8
          if (count_last[c]) begin
            d.ctrl[c][dcc_pkg::POS_END_FLAG] = 1'b1; // RULE14
            d.end_seen[c]                    = 1'b0;
            if (q.ctrl[c][dcc_pkg::POS_IRQ_EN]) begin
              d.stat[c] = 1'b1; // RULE14
            end
          end
        end
        default: begin
          d.st[c] = dcc_pkg::ST_IDLE;
        end
      endcase

      // Acknowledge cycle placement
      d.ack[c] = ack_cycle(single, late, d.st[c]); // RULE5 RULE6
    end

    // Standby entry clears everything
    if (standby_enter) begin
      d = '0; // RULE2
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0; // RULE2
    end else begin
      q <= d;
    end
  end

  // Output polarity and interrupt
  always_comb begin
    for (int c = 0; c < dcc_pkg::NCH; c++) begin
      request_accepted_strobe[c] = q.acc[c] ^ q.ctrl[c][dcc_pkg::POS_ACC_POL]; // RULE4
      transfer_ack_out[c]        = q.ack[c] ^ q.ctrl[c][dcc_pkg::POS_ACK_POL]; // RULE7
    end
  end

  assign irq       = |(q.stat & q.mask);
  assign reg_rdata = q.rdata;
  assign xfer_done = q.done;
  assign src_step  = q.sstep;
  assign dst_step  = q.dstep;

endmodule : dcc_top

// >>> dcc_pkg.sv
// Shared constants and types for the DMA channel control block
package dcc_pkg;

  // Channel count
  localparam int NCH = 2;

  // Register byte offsets on the plain register port
  localparam logic [7:0] ADDR_CTRL0 = 8'h0C;
  localparam logic [7:0] ADDR_CTRL1 = 8'h1C;
  localparam logic [7:0] ADDR_STAT  = 8'h20;
  localparam logic [7:0] ADDR_MASK  = 8'h24;

  // Control register reset value and bit masks
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0007_FF7D;
  localparam logic [31:0] CTRL_RMASK = 32'h0007_FF7F;

  // Control field positions
  localparam int POS_ACC_POL    = 18;
  localparam int POS_ACK_TIME   = 17;
  localparam int POS_ACK_POL    = 16;
  localparam int POS_DST_STEP   = 14;
  localparam int POS_SRC_STEP   = 12;
  localparam int POS_REQ_SRC    = 8;
  localparam int POS_REQ_SAMPLE = 6;
  localparam int POS_XFER_SIZE  = 3;
  localparam int POS_IRQ_EN     = 2;
  localparam int POS_END_FLAG   = 1;
  localparam int POS_CH_EN      = 0;

  // Request source codes
  localparam logic [3:0] SRC_EXT_DUAL = 4'h0;
  localparam logic [3:0] SRC_EXT_M2D  = 4'h2;
  localparam logic [3:0] SRC_EXT_D2M  = 4'h3;
  localparam logic [3:0] SRC_AUTO     = 4'h4;

  // Address step modes
  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_INC   = 2'h1;
  localparam logic [1:0] STEP_DEC   = 2'h2;

  // Transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;

  // Channel sequencer states, Gray along idle-read-write-end
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD   = 2'b01,
    ST_WR   = 2'b11,
    ST_END  = 2'b10
  } dcc_state_t;

  // Single address mode decode
  function automatic logic is_single(input logic [3:0] code);
    is_single = (code == SRC_EXT_M2D) || (code == SRC_EXT_D2M);
  endfunction : is_single

  // External request decode
  function automatic logic is_ext(input logic [3:0] code);
    is_ext = (code == SRC_EXT_DUAL) || is_single(code);
  endfunction : is_ext

endpackage : dcc_pkg

// >>> dcc_step.sv
// Address step value from step mode and transfer size
`timescale 1ns/1ps
module dcc_step (
  // Field inputs
  input  wire logic [1:0] mode,
  input  wire logic [1:0] size,
  input  wire logic       ignore,
  // Signed step
  output logic signed [3:0] step
);

  logic signed [3:0] mag;

  // Magnitude by size, sign by mode
  always_comb begin
    case (size)
      dcc_pkg::SIZE_BYTE: mag = 4'sh1;
      dcc_pkg::SIZE_WORD: mag = 4'sh2;
      default:            mag = 4'sh4;
    endcase
    if (ignore) begin
      step = 4'sh0;
    end else if (mode == dcc_pkg::STEP_INC) begin
      step = mag;
    end else if (mode == dcc_pkg::STEP_DEC) begin
      step = -mag;
    end else begin
      step = 4'sh0;
    end
  end

endmodule : dcc_step

// >>> dcc_req_detect.sv
// Transfer request detection for one channel
`timescale 1ns/1ps
module dcc_req_detect (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clear,
  // Request inputs
  input  wire logic        transfer_request_in_n,
  input  wire logic [15:0] periph_evt,
  // Control fields
  input  wire logic [3:0]  source,
  input  wire logic        sample_sel,
  input  wire logic        enable,
  input  wire logic        take,
  // Request out
  output logic             pending
);

  typedef struct packed {
    logic prev_n;
    logic pend;
  } dcc_rq_t;

  dcc_rq_t q;
  dcc_rq_t d;
  logic    ext;
  logic    hit;

  // Edge or event capture, level mode passes through
  always_comb begin
    d        = q;
    ext      = dcc_pkg::is_ext(source);
    d.prev_n = transfer_request_in_n;
    if (ext) begin
      hit = q.prev_n && !transfer_request_in_n;
    end else begin
      hit = periph_evt[source];
    end
    d.pend = enable && (q.pend || hit) && !take;
    if (clear) begin
      d.pend = 1'b0;
    end
    if (source == dcc_pkg::SRC_AUTO) begin
      pending = enable;
    end else if (ext && !sample_sel) begin
      pending = enable && !transfer_request_in_n; // RULE13
    end else begin
      pending = q.pend; // RULE13
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{prev_n: 1'b1, pend: 1'b0};
    end else begin
      q <= d;
    end
  end

endmodule : dcc_req_detect

// >>> dcc_properties.sv
// Port checker for the DMA channel control block
`timescale 1ns/1ps
module dcc_properties (
  // Clock, reset and standby
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic            standby_enter,
  // Register port
  input wire logic [7:0]      reg_addr,
  input wire logic [31:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic [31:0]     reg_rdata,
  // Channel outputs
  input wire logic [1:0]      request_accepted_strobe,
  input wire logic [1:0]      transfer_ack_out,
  input wire logic [1:0]      xfer_done,
  input wire logic [1:0][3:0] src_step,
  input wire logic [1:0][3:0] dst_step,
  input wire logic            irq
);
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic        acc0;
  logic        ack0;
  logic        single0;

  // Shadow of channel 0 control writes
  always_comb begin
    cfg_d = cfg_q;
    if (standby_enter) cfg_d = '0;
    else if (reg_wr && reg_addr == dcc_pkg::ADDR_CTRL0) cfg_d = reg_wdata;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cfg_q <= '0;
    else cfg_q <= cfg_d;
  end

  // Active levels after polarity
  assign acc0 = request_accepted_strobe[0] ^ cfg_q[18];
  assign ack0 = transfer_ack_out[0] ^ cfg_q[16];
  assign single0 = (cfg_q[11:8] == 4'h2) || (cfg_q[11:8] == 4'h3);

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Accepted request and cycle kinds
  sequence s_accept;
    acc0 && !reg_wr;
  endsequence
  sequence s_ack_late;
    !ack0 ##1 ack0;
  endsequence

  a_rsvd_zero: assert property (reg_rdata[31:19] == 13'h0 && !reg_rdata[7])
    else $error("reserved read bits not zero");
  a_accept_pulse: assert property (s_accept |=> !acc0)
    else $error("accept strobe longer than one cycle");
  a_ack_read: assert property (s_accept ##0 (!single0 && !cfg_q[17]) |-> ack0)
    else $error("acknowledge missing in read cycle");
  a_ack_write: assert property (s_accept ##0 (!single0 && cfg_q[17]) |-> s_ack_late)
    else $error("acknowledge missing in write cycle");
  a_ack_single: assert property (s_accept ##0 single0 |-> ack0)
    else $error("acknowledge missing in single address transfer");
  a_ack_pulse: assert property (ack0 && !reg_wr |=> !ack0)
    else $error("acknowledge longer than one cycle");
  a_done_time: assert property (s_accept ##0 !single0 |-> ##3 xfer_done[0])
    else $error("transfer end not three cycles after accept");
  a_done_single: assert property (s_accept ##0 single0 |-> ##2 xfer_done[0])
    else $error("single transfer end not two cycles after accept");
  a_step_hold: assert property (!xfer_done[0] && !$past(standby_enter)
    |-> $stable(src_step[0]) && $stable(dst_step[0]))
    else $error("step changed without transfer end");
  a_standby_clr: assert property (standby_enter |=> !irq && !xfer_done[0] && reg_rdata == 32'h0000_0000)
    else $error("standby did not clear state");
endmodule : dcc_properties

bind dcc_top dcc_properties chk_u (
  .clk(clk), .sys_rst(sys_rst), .standby_enter(standby_enter), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .request_accepted_strobe(request_accepted_strobe), .transfer_ack_out(transfer_ack_out),
  .xfer_done(xfer_done), .src_step(src_step), .dst_step(dst_step), .irq(irq));

// >>> dcc_requester.sv
// Model of an external device requesting transfers
`timescale 1ns/1ps
module dcc_requester (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Bench control
  input  wire logic go,
  input  wire logic keep,
  input  wire logic pol,
  // Request pins
  input  wire logic accept,
  output logic      req_n
);
  logic keep_q;

  // Hold request low until accepted or a held stretch ends, then pull-up level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_n  <= 1'b1;
      keep_q <= 1'b0;
    end else begin
      keep_q <= keep;
      if (go || keep) req_n <= 1'b0;
      else if ((accept ^ pol) || keep_q) req_n <= 1'b1;
    end
  end
endmodule : dcc_requester

// >>> tb_dcc_top.sv
// Self-checking bench for the DMA channel control block
`timescale 1ns/1ps
module tb_dcc_top;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             standby_enter = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0000_0000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata;
  logic [15:0]      periph_evt = 16'h0000;
  logic [1:0]       count_last = 2'h3;
  logic             go = 1'b0;
  logic             keep = 1'b0;
  logic             req_n;
  logic [1:0]       acc;
  logic [1:0]       ack;
  logic [1:0]       xfer_done;
  logic [1:0][3:0]  src_step;
  logic [1:0][3:0]  dst_step;
  logic             irq;
  int               errors = 0;
  int               tests_run = 0;

  // Clock
  always #4 clk = ~clk;

  dcc_top dut_u (
    .clk(clk), .sys_rst(sys_rst), .standby_enter(standby_enter), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transfer_request_in_n({1'b1, req_n}), .periph_evt(periph_evt),
    .request_accepted_strobe(acc), .transfer_ack_out(ack), .count_last(count_last),
    .xfer_done(xfer_done), .src_step(src_step), .dst_step(dst_step), .irq(irq));

  dcc_requester req_u (.clk(clk), .sys_rst(sys_rst), .go(go), .keep(keep), .pol(1'b0), .accept(acc[0]),
    .req_n(req_n));

  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask : rd

  // Bounded wait for transfer end, then step check
  task automatic wait_done(input logic [3:0] se, input logic [3:0] de);
    int i;
    for (i = 0; i < 40 && xfer_done[0] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("xfer_done", 32'h1, {31'h0, xfer_done[0]});
    if (i == 40) conclude();
    chk("src_step", {28'h0, se}, {28'h0, src_step[0]});
    chk("dst_step", {28'h0, de}, {28'h0, dst_step[0]});
  endtask : wait_done

  task automatic t_regs();
    rd(dcc_pkg::ADDR_CTRL0, 32'h0, "ctrl0");
    rd(dcc_pkg::ADDR_CTRL1, 32'h0, "ctrl1");
    wr(dcc_pkg::ADDR_CTRL1, 32'hFFFF_FFFF);
    rd(dcc_pkg::ADDR_CTRL1, 32'h0007_FF7D, "ctrl1");
    chk("accept1_idle", 32'h1, {31'h0, acc[1]});
    chk("ack1_idle", 32'h1, {31'h0, ack[1]});
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0, "unmapped");
    wr(dcc_pkg::ADDR_CTRL1, 32'h0);
  endtask : t_regs

  // Auto request, word size, both polarities low
  task automatic t_irq();
    wr(dcc_pkg::ADDR_MASK, 32'h1);
    wr(dcc_pkg::ADDR_CTRL0, 32'h0005_940D);
    wait_done(4'h2, 4'hE);
    chk("accept_idle", 32'h1, {31'h0, acc[0]});
    chk("ack_idle", 32'h1, {31'h0, ack[0]});
    chk("irq", 32'h1, {31'h0, irq});
    rd(dcc_pkg::ADDR_CTRL0, 32'h0005_940F, "ctrl0");
    wr(dcc_pkg::ADDR_CTRL0, 32'h0005_940C);
    rd(dcc_pkg::ADDR_CTRL0, 32'h0005_940C, "ctrl0");
    wr(dcc_pkg::ADDR_CTRL0, 32'h0005_940E);
    rd(dcc_pkg::ADDR_CTRL0, 32'h0005_940C, "ctrl0");
    wr(dcc_pkg::ADDR_MASK, 32'h0);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    rd(dcc_pkg::ADDR_STAT, 32'h1, "status");
    rd(dcc_pkg::ADDR_STAT, 32'h0, "status");
  endtask : t_irq

  // External and peripheral sources, both acknowledge timings
  task automatic t_modes();
    logic [3:0] codes [4] = '{4'h0, 4'h2, 4'h3, 4'h6};
    logic [31:0] cfg;
    for (int i = 0; i < 4; i++) begin
      cfg = {14'h0, i[0], 5'h05, codes[i], 8'h01};
      wr(dcc_pkg::ADDR_CTRL0, cfg);
      @(posedge clk);
      if (codes[i] == 4'h6) periph_evt <= 16'h0040;
      else go <= 1'b1;
      @(posedge clk);
      periph_evt <= 16'h0000;
      go <= 1'b0;
      wait_done(codes[i] == 4'h3 ? 4'h0 : 4'h1, codes[i] == 4'h3 ? 4'h0 : 4'h1);
      rd(dcc_pkg::ADDR_CTRL0, cfg | 32'h2, "ctrl0");
    end
  endtask : t_modes

  // Falling-edge sampling takes one transfer from a held request
  task automatic t_edge();
    int n;
    n = 0;
    count_last <= 2'h0;
    wr(dcc_pkg::ADDR_CTRL0, 32'h0000_5041);
    keep <= 1'b1;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (xfer_done[0] === 1'b1) n++;
    end
    chk("edge_count", 32'h1, n);
    wr(dcc_pkg::ADDR_CTRL0, 32'h0000_0000);
    keep <= 1'b0;
    count_last <= 2'h3;
  endtask : t_edge

  task automatic t_standby();
    wr(dcc_pkg::ADDR_CTRL0, 32'h0001_0000);
    standby_enter <= 1'b1;
    @(posedge clk);
    standby_enter <= 1'b0;
    rd(dcc_pkg::ADDR_CTRL0, 32'h0, "ctrl0");
    chk("ack_idle", 32'h0, {31'h0, ack[0]});
  endtask : t_standby

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_irq();
    t_modes();
    t_edge();
    t_standby();
    conclude();
  end
endmodule : tb_dcc_top
